// file: bench/oscsel_osc_model.sv
// free-running raw clock sources facing the select block
`timescale 1ns/100ps
`default_nettype none
module oscsel_osc_model #(
    parameter int HALF_INT = 4,
    parameter int HALF_OSC = 6,
    parameter int HALF_BUS = 10
) (
    input  wire logic clk_sys,
    output logic      internal_osc_clk,
    output logic      osc_pin_in,
    output logic      bus_clk
);
    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    // halves are whole clk_sys periods so the 2-ff sampling never misses an edge
    int cnt = 0;
    initial begin
        internal_osc_clk = 1'b0;
        osc_pin_in       = 1'b0;
        bus_clk          = 1'b0;
    end
    always @(posedge clk_sys) begin
        cnt <= cnt + 1;
        if (cnt % HALF_INT == 0) internal_osc_clk <= ~internal_osc_clk;
        // one pin shared by rc and crystal, so one source here
        if (cnt % HALF_OSC == 0) osc_pin_in <= ~osc_pin_in;
        if (cnt % HALF_BUS == 0) bus_clk <= ~bus_clk;
    end
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the oscillator clock select block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import oscsel_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int WIN = 120;
    localparam int NI  = WIN / 4;
    localparam int NO  = WIN / 6;
    localparam int NB  = WIN / 10;
    logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [1:0]  option_nv = 2'h1;
    logic        sysint_osc_enable = 1'b1, wait_req = 1'b0, stop_req = 1'b0, break_req = 1'b0;
    logic        internal_osc_clk, osc_pin_in, bus_clk, main_ref_clk, pll_ref_clk;
    logic        timebase_ref_clk, watchdog_ref_clk, osc_pin_out;
    logic        internal_osc_run, rc_osc_run, crystal_osc_run;
    logic [4:0]  outs, outs_q = 5'h00;
    int          tog[5] = '{0, 0, 0, 0, 0};
    int          error_cnt = 0, tests_run = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    oscsel_osc_model oscsel_osc_model_i (.clk_sys(clk_sys), .internal_osc_clk(internal_osc_clk),
        .osc_pin_in(osc_pin_in), .bus_clk(bus_clk));
    oscsel_top oscsel_top_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .option_nv(option_nv), .internal_osc_clk(internal_osc_clk), .osc_pin_in(osc_pin_in),
        .bus_clk(bus_clk), .sysint_osc_enable(sysint_osc_enable), .wait_req(wait_req),
        .stop_req(stop_req), .break_req(break_req), .main_ref_clk(main_ref_clk),
        .pll_ref_clk(pll_ref_clk), .timebase_ref_clk(timebase_ref_clk),
        .watchdog_ref_clk(watchdog_ref_clk), .osc_pin_out(osc_pin_out),
        .internal_osc_run(internal_osc_run), .rc_osc_run(rc_osc_run),
        .crystal_osc_run(crystal_osc_run));
    assign outs = {osc_pin_out, watchdog_ref_clk, timebase_ref_clk, pll_ref_clk, main_ref_clk};
    always @(posedge clk_sys) begin
        outs_q <= outs;
        for (int i = 0; i < 5; i++) if (outs[i] !== outs_q[i]) tog[i] <= tog[i] + 1;
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            error_cnt++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    function automatic bit near(int got, int e);
        return (e < 0) || (got >= e - 1 && got <= e + 1);
    endfunction
    task automatic do_reset(input logic [1:0] code);
        option_nv <= code;
        reset     <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata === e, "read data");
        @(posedge clk_sys);
        #1 check(reg_rdata === 8'h00, "read data not cleared");
    endtask
    // counts edges over a window; negative expectation skips that output
    task automatic meas(input int em, input int et, input int ep, input int ew = NI);
        int s[5];
        repeat (6) @(posedge clk_sys);
        s = tog;
        repeat (WIN) @(posedge clk_sys);
        #1 check(near(tog[0] - s[0], em), "main rate");
        check(near(tog[1] - s[1], em), "pll rate");
        check(near(tog[2] - s[2], et), "timebase rate");
        check(near(tog[3] - s[3], ew), "watchdog rate");
        check(near(tog[4] - s[4], ep), "pin out rate");
    endtask
    task automatic stop_try(input logic [7:0] cfg, input logic e_run, input logic e_int);
        wr(OSCSEL_CONFIG_TWO_ADDR, cfg);
        stop_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(crystal_osc_run === e_run, "crystal in stop");
        check(internal_osc_run === e_int, "internal in stop");
        meas(e_run ? NO : 0, -1, -1, e_int ? NI : 0);
        stop_req <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            check(internal_osc_run === 1'b1, "internal not running");
            check(rc_osc_run === (m == 2) && crystal_osc_run === (m == 3), "rc crystal");
            rd(OSCSEL_OPTION_ADDR, 8'(m));
            for (int t = 0; t < 4; t++) begin
                wr(OSCSEL_CONFIG_TWO_ADDR, 8'(t));
                meas(m == 0 ? 0 : m == 1 ? NI : NO, t == 0 ? NI :
                    ((t == 1 && m == 2) || (t == 2 && m == 3)) ? NO : 0,
                    m == 3 ? NO : NB);
            end
        end
        // crystal left as main and pll reference
        wr(OSCSEL_CONFIG_TWO_ADDR, 8'hff);
        rd(OSCSEL_CONFIG_TWO_ADDR, 8'h1f);
        wr(OSCSEL_OPTION_ADDR, 8'h00);
        rd(OSCSEL_OPTION_ADDR, 8'h03);
        rd(16'h0100, 8'h00);
        wr(OSCSEL_CONFIG_TWO_ADDR, 8'h00);
        wait_req  <= 1'b1;
        break_req <= 1'b1;
        meas(NO, NI, NO);
        wait_req  <= 1'b0;
        break_req <= 1'b0;
        stop_try(8'h00, 1'b0, 1'b1);
        stop_try(8'h08, 1'b1, 1'b1);
        stop_try(8'h04, 1'b0, 1'b0);
        sysint_osc_enable <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check(crystal_osc_run === 1'b0 && internal_osc_run === 1'b1, "enable off");
        sysint_osc_enable <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(crystal_osc_run === 1'b1, "enable on");
        test_done();
    end
endmodule
`default_nettype wire

// file: src/oscsel_pkg.sv
// constants and types for the oscillator clock select block
// Functional notes
// - the option register's two select bits pick the main reference: 00 unused, 01 internal, 10 rc, 11 crystal.
// - the config_two two-bit field picks the timebase reference: 00 internal, 01 rc, 10 crystal, 11 unused.
// - the internal oscillator runs from every reset onward, whatever the main selection.
// - rc and crystal circuits never run together; the one not selected is disabled.
// - rc or crystal reaches the timebase only when it is also the main reference; internal always does.
// - with crystal selected the second pin carries the inverted crystal input, else the bus clock.
// - the system integration enable turns the selected oscillator circuit on or off.
// - the pll reference is a buffered copy of the main reference.
// - in wait mode both main and timebase references keep running.
// - stop mode disables rc or crystal and stops the main reference unless its keep bit was set.
// - the internal oscillator runs in stop mode unless its stop-disable bit was set.
// - in break state the main reference keeps running.
// - the watchdog reference is always the internal oscillator.
package oscsel_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] OSCSEL_CONFIG_TWO_ADDR = 16'h001d;
    localparam logic [15:0] OSCSEL_OPTION_ADDR     = 16'hffcf;
    localparam logic [7:0]  OSCSEL_CONFIG_TWO_RST  = 8'h00;
    localparam logic [7:0]  OSCSEL_OPTION_RST      = 8'h01;
    // config_two fields
    localparam int OSCSEL_TB_SEL_LO_POS   = 0;
    localparam int OSCSEL_TB_SEL_HI_POS   = 1;
    localparam int OSCSEL_STOP_INT_DIS_POS = 2;
    localparam int OSCSEL_STOP_XTAL_POS   = 3;
    localparam int OSCSEL_STOP_RC_POS     = 4;
    // option_select fields
    localparam int OSCSEL_MAIN_SEL_LO_POS = 0;
    localparam int OSCSEL_MAIN_SEL_HI_POS = 1;
    // ------------------------------------------------------------
    // source codes
    // ------------------------------------------------------------
    localparam logic [1:0] OSCSEL_MAIN_NONE = 2'h0;
    localparam logic [1:0] OSCSEL_MAIN_INT  = 2'h1;
    localparam logic [1:0] OSCSEL_MAIN_RC   = 2'h2;
    localparam logic [1:0] OSCSEL_MAIN_XTAL = 2'h3;
    localparam logic [1:0] OSCSEL_TB_INT    = 2'h0;
    localparam logic [1:0] OSCSEL_TB_RC     = 2'h1;
    localparam logic [1:0] OSCSEL_TB_XTAL   = 2'h2;
    localparam logic [1:0] OSCSEL_TB_NONE   = 2'h3;
    typedef enum logic [1:0] {
        OSCSEL_RUN,
        OSCSEL_WAIT,
        OSCSEL_STOP
    } oscsel_mode_t;
endpackage

// file: src/oscsel_top.sv
// oscillator source selection, gating and register port
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module oscsel_top (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [1:0]  option_nv,
    input  wire logic        internal_osc_clk,
    input  wire logic        osc_pin_in,
    input  wire logic        bus_clk,
    input  wire logic        sysint_osc_enable,
    input  wire logic        wait_req,
    input  wire logic        stop_req,
    input  wire logic        break_req,
    output logic             main_ref_clk,
    output logic             pll_ref_clk,
    output logic             timebase_ref_clk,
    output logic             watchdog_ref_clk,
    output logic             osc_pin_out,
    output logic             internal_osc_run,
    output logic             rc_osc_run,
    output logic             crystal_osc_run
);
    import oscsel_pkg::*;

    // ------------------------------------------------------------
    // synchronisers for pins and oscillator inputs
    // ------------------------------------------------------------
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    always_ff @(posedge clk_sys) begin
        sync1_reg <= {option_nv, internal_osc_clk, osc_pin_in, bus_clk,
                      sysint_osc_enable, wait_req, stop_req, break_req};
        sync2_reg <= sync1_reg;
    end
    logic [1:0] nv_s;
    logic       internal_osc_clk_s;
    logic       pin_s;
    logic       bclk_s;
    logic       en_s;
    logic       wait_s;
    logic       stop_s;
    logic       brk_s;
    assign {nv_s, internal_osc_clk_s, pin_s, bclk_s, en_s, wait_s, stop_s, brk_s} = sync2_reg;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] config_two_reg;
    logic [7:0] option_select_reg;
    logic       strap_done_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            config_two_reg <= OSCSEL_CONFIG_TWO_RST;
        end else if (reg_wr && reg_addr == OSCSEL_CONFIG_TWO_ADDR) begin
            config_two_reg <= {3'h0, reg_wdata[4:0]};
        end
    end

    // option bits are non-volatile: caught once after reset release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            option_select_reg <= OSCSEL_OPTION_RST;
            strap_done_reg    <= 1'b0;
        end else if (!strap_done_reg) begin
            option_select_reg <= {6'h00, nv_s};
            strap_done_reg    <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OSCSEL_CONFIG_TWO_ADDR: reg_rdata <= config_two_reg;
                OSCSEL_OPTION_ADDR:     reg_rdata <= option_select_reg;
                default:                reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    logic [1:0] main_sel;
    logic [1:0] tb_sel;
    assign main_sel = {option_select_reg[OSCSEL_MAIN_SEL_HI_POS],
                       option_select_reg[OSCSEL_MAIN_SEL_LO_POS]};
    assign tb_sel   = {config_two_reg[OSCSEL_TB_SEL_HI_POS],
                       config_two_reg[OSCSEL_TB_SEL_LO_POS]};

    // ------------------------------------------------------------
    // power mode; stop is left only by a reset or by stop_req dropping
    // ------------------------------------------------------------
    oscsel_mode_t mode_reg;
    oscsel_mode_t mode_next;
    always_comb begin
        case (mode_reg)
            OSCSEL_RUN:  mode_next = stop_s ? OSCSEL_STOP : (wait_s ? OSCSEL_WAIT : OSCSEL_RUN);
            OSCSEL_WAIT: mode_next = stop_s ? OSCSEL_STOP : (wait_s ? OSCSEL_WAIT : OSCSEL_RUN);
            OSCSEL_STOP: mode_next = stop_s ? OSCSEL_STOP : OSCSEL_RUN;
            default:     mode_next = OSCSEL_RUN;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_reg <= OSCSEL_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // keep bits are latched on stop entry, so later writes do not matter
    logic stop_keep_int_reg;
    logic stop_keep_xtal_reg;
    logic stop_keep_rc_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stop_keep_int_reg  <= 1'b1;
            stop_keep_xtal_reg <= 1'b0;
            stop_keep_rc_reg   <= 1'b0;
        end else if (mode_reg != OSCSEL_STOP && mode_next == OSCSEL_STOP) begin
            stop_keep_int_reg  <= !config_two_reg[OSCSEL_STOP_INT_DIS_POS];
            stop_keep_xtal_reg <= config_two_reg[OSCSEL_STOP_XTAL_POS];
            stop_keep_rc_reg   <= config_two_reg[OSCSEL_STOP_RC_POS];
        end
    end

    // ------------------------------------------------------------
    // oscillator enables and clock gating
    // ------------------------------------------------------------
    logic in_stop;
    logic int_run;
    logic rc_run;
    logic xtal_run;
    assign in_stop = (mode_reg == OSCSEL_STOP);
    // wait and break leave every source untouched
    assign int_run  = (main_sel == OSCSEL_MAIN_INT ? en_s : 1'b1)
                      && !(in_stop && !stop_keep_int_reg);
    assign rc_run   = en_s && main_sel == OSCSEL_MAIN_RC
                      && !(in_stop && !stop_keep_rc_reg);
    assign xtal_run = en_s && main_sel == OSCSEL_MAIN_XTAL
                      && !(in_stop && !stop_keep_xtal_reg);

    logic int_clk;
    logic rc_clk;
    logic xtal_clk;
    logic main_clk;
    logic tb_clk;
    assign int_clk  = internal_osc_clk_s && int_run;
    assign rc_clk   = pin_s && rc_run;
    assign xtal_clk = pin_s && xtal_run;

    always_comb begin
        case (main_sel)
            OSCSEL_MAIN_INT:  main_clk = int_clk;
            OSCSEL_MAIN_RC:   main_clk = rc_clk;
            OSCSEL_MAIN_XTAL: main_clk = xtal_clk;
            default:          main_clk = 1'b0;
        endcase
    end
    always_comb begin
        case (tb_sel)
            OSCSEL_TB_INT:  tb_clk = int_clk;
            OSCSEL_TB_RC:   tb_clk = rc_clk;
            OSCSEL_TB_XTAL: tb_clk = xtal_clk;
            default:        tb_clk = 1'b0;
        endcase
    end

    // outputs registered, one clk_sys of delay on every reference
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            main_ref_clk     <= 1'b0;
            pll_ref_clk      <= 1'b0;
            timebase_ref_clk <= 1'b0;
            watchdog_ref_clk <= 1'b0;
            osc_pin_out      <= 1'b0;
            internal_osc_run <= 1'b1;
            rc_osc_run       <= 1'b0;
            crystal_osc_run  <= 1'b0;
        end else begin
            main_ref_clk     <= main_clk;
            pll_ref_clk      <= main_clk;
            timebase_ref_clk <= tb_clk;
            watchdog_ref_clk <= int_clk;
            osc_pin_out      <= (main_sel == OSCSEL_MAIN_XTAL) ? (xtal_run && !pin_s)
                                                               : bclk_s;
            internal_osc_run <= int_run;
            rc_osc_run       <= rc_run;
            crystal_osc_run  <= xtal_run;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_never_both_run: assert property (@(posedge clk_sys) disable iff (reset)
        !(rc_osc_run && crystal_osc_run)) else $error("rc and crystal both running");
    chk_pll_copy: assert property (@(posedge clk_sys) disable iff (reset)
        pll_ref_clk == main_ref_clk) else $error("pll reference differs from main");
    chk_unused_low: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel == OSCSEL_MAIN_NONE |=> !main_ref_clk) else $error("unused main code toggles");
    chk_tb_rc_gate: assert property (@(posedge clk_sys) disable iff (reset)
        (tb_sel == OSCSEL_TB_RC && main_sel != OSCSEL_MAIN_RC) |=> !timebase_ref_clk)
        else $error("rc clock reached timebase unselected");
    // the edge right after reset still shows the reset value, so skip it
    chk_wdog_int: assert property (@(posedge clk_sys) disable iff (reset)
        !$past(reset) |-> watchdog_ref_clk == $past(int_clk))
        else $error("watchdog not on internal clock");
    chk_stop_xtal: assert property (@(posedge clk_sys) disable iff (reset)
        (in_stop && !stop_keep_xtal_reg) |=> !crystal_osc_run)
        else $error("crystal ran in stop");
    chk_int_stop_keep: assert property (@(posedge clk_sys) disable iff (reset)
        (in_stop && stop_keep_int_reg && main_sel != OSCSEL_MAIN_INT) |=> internal_osc_run)
        else $error("internal stopped wrongly");
    chk_wait_runs: assert property (@(posedge clk_sys) disable iff (reset)
        (mode_reg == OSCSEL_WAIT && main_sel == OSCSEL_MAIN_XTAL && en_s) |=> crystal_osc_run)
        else $error("wait stopped crystal");
    chk_enable_off: assert property (@(posedge clk_sys) disable iff (reset)
        !en_s |=> !rc_osc_run && !crystal_osc_run) else $error("enable ignored");

    // ------------------------------------------------------------
    // further checks, stop entry built from named sequences
    // ------------------------------------------------------------
    sequence s_stop_entry;
        mode_reg != OSCSEL_STOP && mode_next == OSCSEL_STOP;
    endsequence
    sequence s_xtal_stopped;
        in_stop && !stop_keep_xtal_reg && main_sel == OSCSEL_MAIN_XTAL;
    endsequence
    chk_break_runs: assert property (@(posedge clk_sys) disable iff (reset)
        (brk_s && !in_stop && main_sel == OSCSEL_MAIN_XTAL && en_s) |=> crystal_osc_run)
        else $error("break stopped crystal");
    chk_rc_unsel: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel != OSCSEL_MAIN_RC |=> !rc_osc_run) else $error("rc runs unselected");
    chk_xtal_unsel: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel != OSCSEL_MAIN_XTAL |=> !crystal_osc_run)
        else $error("crystal runs unselected");
    chk_int_after_rst: assert property (@(posedge clk_sys) disable iff (reset)
        $past(reset) |-> internal_osc_run) else $error("internal off after reset");
    chk_main_int: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel == OSCSEL_MAIN_INT |=> main_ref_clk == $past(int_clk))
        else $error("main not internal");
    chk_main_rc: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel == OSCSEL_MAIN_RC |=> main_ref_clk == $past(rc_clk))
        else $error("main not rc");
    chk_main_xtal: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel == OSCSEL_MAIN_XTAL |=> main_ref_clk == $past(xtal_clk))
        else $error("main not crystal");
    chk_tb_int: assert property (@(posedge clk_sys) disable iff (reset)
        tb_sel == OSCSEL_TB_INT |=> timebase_ref_clk == $past(int_clk))
        else $error("timebase not internal");
    chk_tb_unused: assert property (@(posedge clk_sys) disable iff (reset)
        tb_sel == OSCSEL_TB_NONE |=> !timebase_ref_clk)
        else $error("unused timebase code toggles");
    chk_pin_bus: assert property (@(posedge clk_sys) disable iff (reset)
        main_sel != OSCSEL_MAIN_XTAL |=> osc_pin_out == $past(bclk_s))
        else $error("pin out not bus clock");
    chk_pin_xtal: assert property (@(posedge clk_sys) disable iff (reset)
        (main_sel == OSCSEL_MAIN_XTAL && xtal_run) |=> osc_pin_out == !$past(pin_s))
        else $error("pin out not inverted crystal");
    chk_keep_latch: assert property (@(posedge clk_sys) disable iff (reset)
        s_stop_entry |=> stop_keep_xtal_reg == $past(config_two_reg[OSCSEL_STOP_XTAL_POS])
                         && stop_keep_rc_reg == $past(config_two_reg[OSCSEL_STOP_RC_POS]))
        else $error("keep bits not latched");
    chk_int_latch: assert property (@(posedge clk_sys) disable iff (reset)
        s_stop_entry |=> stop_keep_int_reg == !$past(config_two_reg[OSCSEL_STOP_INT_DIS_POS]))
        else $error("internal keep not latched");
    chk_stop_int_off: assert property (@(posedge clk_sys) disable iff (reset)
        (in_stop && !stop_keep_int_reg) |=> !internal_osc_run)
        else $error("internal ran in stop");
    chk_stop_main_low: assert property (@(posedge clk_sys) disable iff (reset)
        s_xtal_stopped |=> !main_ref_clk) else $error("main ran in stop");
    chk_wait_main: assert property (@(posedge clk_sys) disable iff (reset)
        (mode_reg == OSCSEL_WAIT && main_sel == OSCSEL_MAIN_XTAL) |=>
        main_ref_clk == $past(xtal_clk)) else $error("wait froze main");
    chk_cfg_upper: assert property (@(posedge clk_sys) disable iff (reset)
        config_two_reg[7:5] == 3'h0) else $error("config upper bits set");
    chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data left standing");
    chk_mode_legal: assert property (@(posedge clk_sys) disable iff (reset)
        mode_reg inside {OSCSEL_RUN, OSCSEL_WAIT, OSCSEL_STOP})
        else $error("mode out of range");
endmodule
`default_nettype wire
